// ### rtl/fuse_programmer.sv
`timescale 1ns/1ps
`default_nettype none
module fuse_programmer #(
	parameter int OFF_CYC = fuse_prog_pkg::OFF_CYC
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire logic [1:0] cmd_kind_in,
	input wire logic [5:0] cmd_term_in,
	input wire logic [3:0] cmd_input_in,
	input wire logic cmd_level_in,
	input wire logic [11:0] cmd_pattern_in,
	input wire logic [2:0] cmd_output_in,
	input wire logic pkg_enable_in,
	output logic done_out,
	output logic skipped_out,
	output logic refused_out,
	output logic [5:0] verify_data_out,
	output logic term_complete_out,
	output logic [1:0] supply_sel_out,
	output logic [11:0] in_elev_out,
	output logic [11:0] in_level_out,
	output logic [5:0] func_out,
	output logic [5:0] func_oe_out,
	input wire logic [5:0] func_in,
	output logic [5:0] or_link_select_level_out
);
	fuse_prog_pkg::state_t state, next_state;
	fuse_prog_pkg::cnt_t cnt, next_cnt;
	logic [1:0] kind;
	logic [5:0] term;
	logic [3:0] inp;
	logic lvl;
	logic [11:0] pattern;
	logic [2:0] outsel;
	logic [5:0] cur_term;
	logic term_valid;
	logic [11:0] open_hi, open_lo;
	logic pol_started;

	// Command decode and refusal
	wire is_and = cmd_kind_in == fuse_prog_pkg::CMD_AND;
	wire is_or = cmd_kind_in == fuse_prog_pkg::CMD_OR;
	wire is_pol = cmd_kind_in == fuse_prog_pkg::CMD_POL;
	wire idle = state == fuse_prog_pkg::ST_IDLE;
	wire [11:0] links_done = open_hi | open_lo;
	// With pkg_enable_in set, the enable input needs both links open in every term
	wire enable_ok = !pkg_enable_in ||
		(open_hi[fuse_prog_pkg::ENABLE_INPUT] &&
		open_lo[fuse_prog_pkg::ENABLE_INPUT]);
	wire term_complete = term_valid && (&links_done) && enable_ok;
	// A new address is refused while the open term lacks inputs
	wire lock_hit = is_and && term_valid && !term_complete &&
		cmd_term_in != cur_term;
	wire range_bad = (!is_pol && cmd_term_in > fuse_prog_pkg::LAST_TERM) ||
		(is_and && cmd_input_in > fuse_prog_pkg::ENABLE_INPUT) ||
		(!is_pol && cmd_output_in > fuse_prog_pkg::TOP_OUTPUT &&
		is_or) || (is_pol &&
		cmd_output_in > fuse_prog_pkg::TOP_OUTPUT) ||
		cmd_kind_in == 2'h3;
	// Once polarity work starts, array commands are out of order
	wire order_bad = pol_started && !is_pol;
	wire refuse = lock_hit || range_bad || order_bad;
	// OR work may come per term or after all terms alike
	wire accept = cmd_valid_in && idle && !refuse;
	assign cmd_ready_out = idle;
	assign term_complete_out = term_complete;

	// Latched command kind flags
	wire k_and = kind == fuse_prog_pkg::CMD_AND;
	wire k_or = kind == fuse_prog_pkg::CMD_OR;
	wire k_pol = kind == fuse_prog_pkg::CMD_POL;
	wire cnt_zero = cnt == '0;
	// False output means no pulse is needed; output is active high here
	wire or_skip = k_or && !func_in[outsel];
	wire [2:0] pol_off = fuse_prog_pkg::TOP_OUTPUT - outsel;
	wire [5:0] pol_term = fuse_prog_pkg::POL_TERM_BASE + {3'h0, pol_off};

	// Sequencer: each step times out on the shared down counter
	always_comb begin
		next_state = state;
		next_cnt = cnt_zero ? cnt : cnt - 1'b1;
		case (state)
			fuse_prog_pkg::ST_IDLE: begin
				if (accept) begin
					next_state = fuse_prog_pkg::ST_SETUP;
					next_cnt = fuse_prog_pkg::cnt_t'(fuse_prog_pkg::SETTLE_CYC - 1);
				end
			end
			fuse_prog_pkg::ST_SETUP: begin
				if (cnt_zero && or_skip) begin
					next_state = fuse_prog_pkg::ST_IDLE;
				end else if (cnt_zero) begin
					next_state = fuse_prog_pkg::ST_ARM;
					next_cnt = fuse_prog_pkg::cnt_t'(fuse_prog_pkg::SETTLE_CYC - 1);
				end
			end
			fuse_prog_pkg::ST_ARM: begin
				if (cnt_zero) begin
					next_state = fuse_prog_pkg::ST_PULSE;
					next_cnt = fuse_prog_pkg::cnt_t'(fuse_prog_pkg::PULSE_CYC - 1);
				end
			end
			fuse_prog_pkg::ST_PULSE: begin
				if (cnt_zero) begin
					next_state = fuse_prog_pkg::ST_RECOVER;
					next_cnt = fuse_prog_pkg::cnt_t'(fuse_prog_pkg::SETTLE_CYC - 1);
				end
			end
			fuse_prog_pkg::ST_RECOVER: begin
				if (cnt_zero) begin
					next_state = fuse_prog_pkg::ST_VERIFY;
					next_cnt = fuse_prog_pkg::cnt_t'(fuse_prog_pkg::SETTLE_CYC - 1);
				end
			end
			fuse_prog_pkg::ST_VERIFY: begin
				if (cnt_zero) begin
					next_state = fuse_prog_pkg::ST_COOL;
					next_cnt = fuse_prog_pkg::cnt_t'(OFF_CYC - 1);
				end
			end
			fuse_prog_pkg::ST_COOL: begin
				if (cnt_zero) begin
					next_state = fuse_prog_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = fuse_prog_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			state <= fuse_prog_pkg::ST_IDLE;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// Command latch
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			kind <= 2'h0;
			term <= 6'h00;
			inp <= 4'h0;
			lvl <= 1'b0;
			pattern <= 12'h000;
			outsel <= 3'h0;
		end else if (accept) begin
			kind <= cmd_kind_in;
			term <= cmd_term_in;
			inp <= cmd_input_in;
			lvl <= cmd_level_in;
			pattern <= cmd_pattern_in;
			outsel <= cmd_output_in;
		end
	end

	// Link bookkeeping for the open term; readdressing a finished term
	// starts a fresh record so expanded inputs can be opened later
	wire pulse_end = state == fuse_prog_pkg::ST_PULSE && cnt_zero;
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			cur_term <= 6'h3f; // Out of range, so term 0 opens a record
			term_valid <= 1'b0;
			open_hi <= 12'h000;
			open_lo <= 12'h000;
		end else if (accept && is_and && cmd_term_in != cur_term) begin
			cur_term <= cmd_term_in;
			term_valid <= 1'b1;
			open_hi <= 12'h000;
			open_lo <= 12'h000;
		end else if (pulse_end && k_and) begin
			// Keeping a level opens the opposite link
			open_lo[inp] <= open_lo[inp] | lvl;
			open_hi[inp] <= open_hi[inp] | !lvl;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			pol_started <= 1'b0;
		end else if (accept && is_pol) begin
			pol_started <= 1'b1;
		end
	end

	// Status strobes and the sampled function pins
	wire setup_end = state == fuse_prog_pkg::ST_SETUP && cnt_zero;
	wire verify_end = state == fuse_prog_pkg::ST_VERIFY && cnt_zero;
	wire cool_end = state == fuse_prog_pkg::ST_COOL && cnt_zero;
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			done_out <= 1'b0;
			skipped_out <= 1'b0;
			refused_out <= 1'b0;
			verify_data_out <= 6'h00;
		end else begin
			done_out <= cool_end;
			skipped_out <= setup_end && or_skip;
			refused_out <= cmd_valid_in && idle && refuse;
			if (verify_end || (setup_end && or_skip)) begin
				verify_data_out <= func_in;
			end
		end
	end

	// Pin plan per step; elevation keeps outputs off while an AND or polarity link burns
	wire hv_win = state == fuse_prog_pkg::ST_SETUP ||
		state == fuse_prog_pkg::ST_ARM ||
		state == fuse_prog_pkg::ST_PULSE ||
		state == fuse_prog_pkg::ST_RECOVER;
	wire arm_win = state == fuse_prog_pkg::ST_ARM ||
		state == fuse_prog_pkg::ST_PULSE ||
		state == fuse_prog_pkg::ST_RECOVER;
	wire [11:0] next_elev, next_level;
	genvar gi;
	generate
		for (gi = 0; gi < fuse_prog_pkg::N_INPUTS; gi++) begin : g_in
			wire own = k_and && inp == 4'(gi);
			assign next_elev[gi] = hv_win && (k_pol || (k_and && !own));
			assign next_level[gi] = own ? lvl : pattern[gi];
		end
	endgenerate
	wire [5:0] or_onehot = 6'h01 << outsel;
	wire [5:0] next_or_sel = (k_or && arm_win) ? or_onehot : 6'h00;
	wire [5:0] next_func_oe = ((k_and || k_pol) && hv_win) ? 6'h3f :
		next_or_sel;
	// Address sits on the function pins, bit 5 most significant
	wire [5:0] next_func = k_and ? term : (k_pol ? pol_term : 6'h00);
	// Supply is off in idle and cool so each pulse starts from cold
	wire [1:0] next_supply =
		state == fuse_prog_pkg::ST_PULSE ? fuse_prog_pkg::SUP_PROGRAM :
		(idle || state == fuse_prog_pkg::ST_COOL) ? fuse_prog_pkg::SUP_OFF :
		fuse_prog_pkg::SUP_NORMAL;

	// Pins are registered, so they trail the sequencer by one edge
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			supply_sel_out <= fuse_prog_pkg::SUP_OFF;
			in_elev_out <= 12'h000;
			in_level_out <= 12'h000;
			func_out <= 6'h00;
			func_oe_out <= 6'h00;
			or_link_select_level_out <= 6'h00;
		end else begin
			supply_sel_out <= next_supply;
			in_elev_out <= idle ? 12'h000 : next_elev;
			in_level_out <= idle ? 12'h000 : next_level;
			func_out <= next_func;
			func_oe_out <= next_func_oe;
			or_link_select_level_out <= next_or_sel;
		end
	end

	// Helper counters: length of a pulse and of the gap before it
	wire prog = supply_sel_out == fuse_prog_pkg::SUP_PROGRAM;
	fuse_prog_pkg::cnt_t prog_run, gap_run;
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			prog_run <= '0;
			gap_run <= '1;
		end else begin
			prog_run <= prog ? prog_run + 1'b1 : '0;
			gap_run <= prog ? '0 : ((&gap_run) ? gap_run : gap_run + 1'b1);
		end
	end

	AST_PROG_IN_PULSE: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		prog |-> $past(state) == fuse_prog_pkg::ST_PULSE)
		else $error("program supply outside pulse step");
	AST_PULSE_WIDTH: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		$fell(prog) |-> prog_run == fuse_prog_pkg::PULSE_CYC)
		else $error("program pulse width wrong");
	AST_DUTY_GAP: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		$rose(prog) |-> $past(gap_run) >= OFF_CYC)
		else $error("off time too short for duty cycle");
	AST_ELEVEN_HIGH: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		(prog && k_and) |-> $countones(in_elev_out) == 11 &&
		!in_elev_out[inp])
		else $error("wrong inputs elevated during pulse");
	AST_ADDR_DRIVEN: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		(prog && k_and) |-> func_oe_out == 6'h3f && func_out == term)
		else $error("term address not on function pins");
	AST_OR_ONE_LINK: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		(prog && k_or) |-> or_link_select_level_out == or_onehot &&
		func_oe_out == or_onehot)
		else $error("OR pulse not on exactly the chosen output");
	AST_HOLD_AFTER: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		($fell(prog) && k_and) |->
		(in_elev_out != 12'h000 && supply_sel_out ==
		fuse_prog_pkg::SUP_NORMAL) [*8])
		else $error("inputs left programming level too early");
	AST_SUPPLY_OFF: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		$fell(prog) |-> ##[1:90] supply_sel_out == fuse_prog_pkg::SUP_OFF)
		else $error("supply not removed after pulse");
	AST_TERM_LOCK: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		(cmd_valid_in && idle && lock_hit) |=> refused_out &&
		state == fuse_prog_pkg::ST_IDLE)
		else $error("term changed before all inputs done");
	AST_POL_LAST: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		(cmd_valid_in && idle && pol_started && is_or) |=> refused_out)
		else $error("OR work accepted after polarity");
	AST_OR_SKIP: assert property (@(posedge clk_sys_in)
		disable iff (!resetn_in)
		(setup_end && or_skip) |=> skipped_out && !prog)
		else $error("OR link pulsed though output already false");
endmodule // fuse_programmer
`default_nettype wire

// ### rtl/fuse_prog_pkg.sv
`default_nettype none
package fuse_prog_pkg;
	// Clock rate and period
	localparam int CLK_MHZ = 40;
	localparam int CLK_PERIOD_NS = 25;
	// Programming pulse, nominal width; the guaranteed width is 98 us
	localparam int PULSE_US = 100;
	localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
	// Least wait after the supply settles before logic levels are used
	localparam int SETTLE_US = 1;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	// Highest duty cycle, percent; least off time derived, rounded up
	localparam int DUTY_MAX_PCT = 35;
	localparam int OFF_CYC = (PULSE_CYC * (100 - DUTY_MAX_PCT)
		+ DUTY_MAX_PCT - 1) / DUTY_MAX_PCT;
	// Array geometry
	localparam int N_INPUTS = 12;
	localparam int N_OUTPUTS = 6;
	localparam int N_TERMS = 50;
	localparam int TERM_W = 6;
	localparam int INPUT_W = 4;
	localparam int OUTSEL_W = 3;
	localparam logic [INPUT_W-1:0] ENABLE_INPUT = 4'hb;
	localparam logic [TERM_W-1:0] LAST_TERM = 6'h31;
	// Polarity terms: output k uses term POL_TERM_BASE + (5 - k)
	localparam logic [TERM_W-1:0] POL_TERM_BASE = 6'h32;
	localparam logic [OUTSEL_W-1:0] TOP_OUTPUT = 3'h5;
	localparam int CNT_W = 16;
	typedef logic [CNT_W-1:0] cnt_t;
	typedef enum logic [1:0] {
		CMD_AND = 2'h0,
		CMD_OR = 2'h1,
		CMD_POL = 2'h2
	} cmd_kind_t;
	typedef enum logic [1:0] {
		SUP_OFF = 2'h0,
		SUP_NORMAL = 2'h1,
		SUP_PROGRAM = 2'h2
	} supply_t;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_SETUP = 7'h02,
		ST_ARM = 7'h04,
		ST_PULSE = 7'h08,
		ST_RECOVER = 7'h10,
		ST_VERIFY = 7'h20,
		ST_COOL = 7'h40
	} state_t;
endpackage
`default_nettype wire

// ### sim/fpla_device_model.sv
`timescale 1ns/1ps
`default_nettype none
// Fuse array on the far side of the programmer pins
module fpla_device_model (
	input wire logic clk_sys_in,
	input wire logic [1:0] supply_in,
	input wire logic [11:0] elev_in,
	input wire logic [11:0] level_in,
	input wire logic [5:0] func_drv_in,
	input wire logic [5:0] func_oe_in,
	input wire logic [5:0] or_sel_in,
	output logic [5:0] func_pin_out
);
	logic [11:0] hi_ok [0:49];
	logic [11:0] lo_ok [0:49];
	logic [5:0] or_ok [0:49];
	logic [49:0] hit;
	logic [5:0] pol_ok, sop, last;
	logic [1:0] prev;
	logic dev_on;
	// A blank term keeps both levels, so it never hits
	initial begin
		pol_ok = 6'h3f;
		last = 6'h00;
		for (int t = 0; t < 50; t++) begin
			hi_ok[t] = 12'hfff;
			lo_ok[t] = 12'hfff;
			or_ok[t] = 6'h3f;
		end
	end
	// Term decode over all inputs, then the sums
	always_comb begin
		sop = 6'h00;
		for (int t = 0; t < 50; t++) begin
			hit[t] = &((~hi_ok[t] | level_in) & (~lo_ok[t] | ~level_in));
			if (hit[t]) sop = sop | or_ok[t];
		end
	end
	// Released pins toggle so a stale value is never read as valid
	assign dev_on = supply_in == 2'h1 && elev_in == 12'h000;
	assign func_pin_out = (func_oe_in & ~or_sel_in & func_drv_in)
		| (~func_oe_in & (dev_on ? sop ^ ~pol_ok : ~last));
	// A link opens on the step up to program level
	always @(posedge clk_sys_in) begin
		prev <= supply_in;
		last <= func_pin_out;
		if (supply_in == 2'h2 && prev != 2'h2) begin
			if (&elev_in) begin
				if (func_drv_in >= 6'h32 && func_drv_in <= 6'h37)
					pol_ok[6'h37 - func_drv_in] <= 1'b0;
			end else if (elev_in != 12'h000) begin
				for (int i = 0; i < 12; i++) begin
					if (!elev_in[i] && func_drv_in < 6'h32) begin
						if (level_in[i]) lo_ok[func_drv_in][i] <= 1'b0;
						else hi_ok[func_drv_in][i] <= 1'b0;
					end
				end
			end else begin
				for (int t = 0; t < 50; t++) begin
					if (hit[t]) or_ok[t] <= or_ok[t] & ~or_sel_in;
				end
			end
		end
	end
endmodule // fpla_device_model
`default_nettype wire

// ### sim/tb_fuse_programmer.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	error_cnt++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_fuse_programmer;
	localparam int OFF = 50;
	logic clk_sys_in = 1'b0, resetn_in = 1'b0;
	logic cmd_valid_in = 1'b0, cmd_level_in = 1'b0;
	logic [1:0] cmd_kind_in = 2'h0, supply_sel_out, e_kind = 2'h0;
	logic [5:0] cmd_term_in = 6'h00, e_addr = 6'h00, e_oe = 6'h00;
	logic [3:0] cmd_input_in = 4'h0, e_in = 4'h0;
	logic [11:0] cmd_pattern_in = 12'h000, e_elev = 12'h000, pe = 12'h000;
	logic [2:0] cmd_output_in = 3'h0;
	logic cmd_ready_out, done_out, skipped_out, refused_out;
	logic term_complete_out, e_lvl = 1'b0, pkg_enable = 1'b0;
	logic [5:0] verify_data_out, func_out, func_oe_out, func_in;
	logic [5:0] or_link_select_level_out;
	logic [11:0] in_elev_out, in_level_out;
	int error_cnt = 0, n_compared = 0, cyc = 0, pc = 0, oc = OFF, since = 0;
	always #12.5 clk_sys_in = ~clk_sys_in;
	fuse_programmer #(.OFF_CYC(OFF)) fuse_programmer_i (.clk_sys_in,
		.resetn_in, .cmd_valid_in, .cmd_ready_out, .cmd_kind_in,
		.cmd_term_in, .cmd_input_in, .cmd_level_in, .cmd_pattern_in,
		.cmd_output_in, .pkg_enable_in(pkg_enable), .done_out, .skipped_out,
		.refused_out, .verify_data_out, .term_complete_out,
		.supply_sel_out, .in_elev_out, .in_level_out, .func_out,
		.func_oe_out, .func_in, .or_link_select_level_out);
	fpla_device_model fpla_device_model_i (.clk_sys_in,
		.supply_in(supply_sel_out), .elev_in(in_elev_out),
		.level_in(in_level_out), .func_drv_in(func_out),
		.func_oe_in(func_oe_out), .or_sel_in(or_link_select_level_out),
		.func_pin_out(func_in));
	task automatic test_done();
		if (error_cnt == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Pin set-up seen on the first cycle at program level
	task automatic check_step();
		`CHK("cool", 1'b1, oc >= OFF)
		`CHK("elev", e_elev, in_elev_out)
		`CHK("oe", e_kind == 2'h1 ? e_oe : 6'h3f, func_oe_out)
		if (e_kind != 2'h1) `CHK("addr", e_addr, func_out)
		if (e_kind == 2'h0) `CHK("keep", e_lvl, in_level_out[e_in])
		if (e_kind == 2'h1) `CHK("orsel", e_oe, or_link_select_level_out)
	endtask
	// Pulse width, settling and cool-off; also the hang limit
	always @(posedge clk_sys_in) begin
		#1;
		cyc++;
		if (cyc == 90000) begin
			error_cnt++;
			test_done();
		end
		if (supply_sel_out == 2'h2) begin
			if (pc == 0) check_step();
			pc++;
		end else if (pc != 0) begin
			`CHK("pulse", 4000, pc)
			pc = 0;
			oc = 0;
			since = 0;
		end
		if (supply_sel_out == 2'h0) oc++;
		since++;
		if (pe != 12'h000 && in_elev_out == 12'h000)
			`CHK("settle", 1'b1, since >= 40)
		pe = in_elev_out;
	end
	// One command; want: 0 done, 1 skipped, 2 refused
	task automatic cmd(input logic [1:0] k, input logic [5:0] t,
		input logic [3:0] i, input logic lv, input logic [11:0] pt,
		input logic [2:0] o, input logic [1:0] want);
		logic [1:0] res;
		@(negedge clk_sys_in);
		cmd_kind_in = k;
		cmd_term_in = t;
		cmd_input_in = i;
		cmd_level_in = lv;
		cmd_pattern_in = pt;
		cmd_output_in = o;
		cmd_valid_in = 1'b1;
		e_kind = k;
		e_in = i;
		e_lvl = lv;
		e_oe = 6'h01 << o;
		e_addr = (k == 2'h2) ? 6'h37 - {3'h0, o} : t;
		e_elev = k == 2'h0 ? ~(12'h001 << i) : {12{k == 2'h2}};
		res = 2'h3;
		@(posedge clk_sys_in);
		for (int n = 0; n < 6000 && res == 2'h3; n++) begin
			#1;
			if (done_out === 1'b1) res = 2'h0;
			else if (skipped_out === 1'b1) res = 2'h1;
			else if (refused_out === 1'b1) res = 2'h2;
			@(negedge clk_sys_in);
			cmd_valid_in = 1'b0;
			if (res == 2'h3) @(posedge clk_sys_in);
		end
		`CHK("result", want, res)
	endtask
	initial begin
		logic [5:0] t;
		logic [11:0] lv;
		logic [3:0] d;
		logic [2:0] k;
		void'($urandom(32'hd4fdeae8));
		t = 6'($urandom_range(49));
		lv = 12'($urandom);
		d = 4'($urandom_range(11));
		k = 3'($urandom_range(5));
		repeat (2) @(negedge clk_sys_in);
		resetn_in = 1'b1;
		`CHK("ready", 1'b1, cmd_ready_out)
		`CHK("supply", 2'h0, supply_sel_out)
		// Requests out of range
		cmd(2'h3, 6'h00, 4'h0, 1'b0, lv, 3'h0, 2'h2);
		cmd(2'h0, 6'h32, 4'h0, 1'b0, lv, 3'h0, 2'h2);
		cmd(2'h0, 6'h00, 4'hc, 1'b0, lv, 3'h0, 2'h2);
		cmd(2'h1, 6'h00, 4'h0, 1'b0, lv, 3'h6, 2'h2);
		// Every input of a random term, one made don't-care
		for (int i = 0; i < 12; i++) begin
			if (i == 5) begin
				`CHK("complete", 1'b0, term_complete_out)
				cmd(2'h0, t ^ 6'h01, 4'h0, 1'b0, lv, 3'h0, 2'h2);
			end
			cmd(2'h0, t, 4'(i), lv[i], lv, 3'h0, 2'h0);
			if (i == d) cmd(2'h0, t, 4'(i), ~lv[i], lv, 3'h0, 2'h0);
		end
		`CHK("complete", 1'b1, term_complete_out)
		// Enable input must lose both links before the term counts done
		pkg_enable = 1'b1;
		#1;
		`CHK("enable", d == 4'hb, term_complete_out)
		if (d != 4'hb) cmd(2'h0, t, 4'hb, ~lv[11], lv, 3'h0, 2'h0);
		#1;
		`CHK("complete", 1'b1, term_complete_out)
		// Sum link of one output, then the same link again
		lv[d] = 1'($urandom);
		cmd(2'h1, t, 4'h0, 1'b0, lv, k, 2'h0);
		`CHK("sum", 6'h3f & ~(6'h01 << k), verify_data_out)
		cmd(2'h1, t, 4'h0, 1'b0, lv, k, 2'h1);
		// Polarity last; array commands are closed afterwards
		cmd(2'h2, t, 4'h0, 1'b0, lv, k, 2'h0);
		cmd(2'h0, t, 4'h0, 1'b0, lv, k, 2'h2);
		cmd(2'h1, t, 4'h0, 1'b0, lv, k, 2'h2);
		test_done();
	end
endmodule // tb_fuse_programmer
`default_nettype wire
